/* File: dv/core_bus_model.sv */
/*
  Core-side model of the flash controller's register bus: register writes
  and reads, operation launch and stall measurement.
  Assumes a free-running clock and that every call starts just after a
  rising edge; the model issues no access while the stall is high.
*/
`timescale 1ns/1ps
`include "flash_iap_consts.svh"

module core_bus_model (
  input wire logic clk, // System clock.
  input wire logic cpu_stall, // Stall from the controller.
  input wire logic [7:0] sfr_rdata, // Register read data.
  output logic [7:0] sfr_addr, // Register address.
  output logic sfr_wr, // Write strobe.
  output logic [7:0] sfr_wdata, // Write data.
  output logic sfr_rd // Read strobe.
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd = 1'b0;
  end

  // Released lines show the inverse so stale values cannot pass.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    #1;
    sfr_rd = 1'b0;
    sfr_addr = ~a;
    d = sfr_rdata;
  endtask : rd

  // Counts stalled cycles; -1 when the stall never ends.
  task automatic measure(output int n);
    int i;
    n = 0;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk);
      #1;
      if (cpu_stall === 1'b1) n++;
      else if (n > 0 || i > 6) break;
    end
    if (i == 2000) n = -1;
  endtask : measure

  task automatic launch(input logic [7:0] ctl, input logic [7:0] cmd,
                        input logic [7:0] hi, input logic [7:0] lo,
                        input logic [7:0] dat);
    logic [7:0] pc;
    // address and data, then command, then trigger.
    wr(`ADDR_FLASH_ADDRESS_HIGH, hi);
    wr(`ADDR_FLASH_ADDRESS_LOW, lo);
    wr(`ADDR_FLASH_DATA_PORT, dat);
    wr(`ADDR_FLASH_CONTROL, ctl);
    wr(`ADDR_FLASH_COMMAND, cmd);
    // no operation while supply is low.
    rd(`ADDR_POWER_CONTROL, pc);
    if (pc[`BIT_LOW_VOLTAGE_FLAG] !== 1'b1) begin
      wr(`ADDR_FLASH_TRIGGER, `TRIGGER_KEY_FIRST);
      wr(`ADDR_FLASH_TRIGGER, `TRIGGER_KEY_SECOND);
    end
  endtask : launch

  task automatic idle();
    wr(`ADDR_FLASH_CONTROL, 8'h00);
    wr(`ADDR_FLASH_COMMAND, 8'h00);
  endtask : idle
endmodule : core_bus_model

/* File: dv/tb_data_flash_iap_controller.sv */
/*
  Self-checking testbench of the data flash access controller: reset
  values, read, program and erase (the last two at every wait code), refusals, trigger
  sequencing and the low-voltage flag.
  Assumes the core model drives the register bus just after each edge.
*/
`timescale 1ns/1ps
`include "flash_iap_consts.svh"

module tb_data_flash_iap_controller;
  localparam int PU = 2;
  localparam int EU = 5;
  logic clk, reset, low_voltage_detect, app_code_running, cpu_stall;
  logic sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  int mismatches, num_checks, n, w;
  int mult [8] = '{32, 24, 20, 12, 6, 3, 2, 1};
  logic [7:0] ra [8] = '{8'h87, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7,
                         8'h10};
  logic [7:0] rv [8] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08,
                         8'h00};

  data_flash_iap_controller #(.PROGRAM_UNIT_CLKS(PU),
    .ERASE_UNIT_CLKS(EU)) DUT (.clk(clk), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .low_voltage_detect(low_voltage_detect),
    .app_code_running(app_code_running), .cpu_stall(cpu_stall));

  core_bus_model core (.clk(clk), .cpu_stall(cpu_stall),
    .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic stall_chk(input int exp);
    core.measure(n);
    if (n < 0) begin
      check(16'hFFFF, 16'h0000, "stall never ended");
      report_and_stop();
    end else check(n[15:0], exp[15:0], "stall length");
  endtask : stall_chk

  task automatic op(input logic [7:0] ctl, input logic [7:0] cmd,
                    input logic [7:0] hi, input logic [7:0] lo,
                    input logic [7:0] dat, input int exp);
    core.launch(ctl, cmd, hi, lo, dat);
    stall_chk(exp);
    core.idle();
  endtask : op

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp,
                      input string what);
    core.rd(a, d);
    check({8'h00, d}, {8'h00, exp}, what);
  endtask : rchk

  task automatic fread(input logic [7:0] hi, input logic [7:0] lo,
                       input logic [7:0] exp);
    op(8'h87, 8'h01, hi, lo, 8'h00, 2);
    rchk(8'hE2, exp, "flash byte");
  endtask : fread

  initial begin
    reset = 1'b1;
    low_voltage_detect = 1'b0;
    app_code_running = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    for (w = 0; w < 8; w++) rchk(ra[w], rv[w], "reset value");
    $display("test reset values done");
    op(8'h87, 8'h01, 8'h01, 8'h23, 8'h00, 2);
    rchk(8'hE2, 8'hFF, "read data");
    rchk(8'hE3, 8'h01, "address high");
    rchk(8'hE4, 8'h23, "address low");
    rchk(8'hE7, 8'h00, "fail bit");
    $display("test byte read done");
    for (w = 0; w < 8; w++) begin
      op({5'h10, w[2:0]}, 8'h02, 8'h0E, w[7:0], 8'hA5 ^ w[7:0],
         PU * mult[w]);
      fread(8'h0E, w[7:0], 8'hA5 ^ w[7:0]);
    end
    op(8'h87, 8'h02, 8'h0E, 8'h00, 8'h0F, PU);
    fread(8'h0E, 8'h00, 8'h05);
    $display("test byte program done");
    for (w = 0; w < 8; w++) begin
      op({5'h10, w[2:0]}, 8'h03, {4'h0, w[2:0], 1'b0}, 8'h55, 8'h00,
         EU * mult[w]);
      fread(8'h0E, 8'h00, (w == 7) ? 8'hFF : 8'h05);
    end
    fread(8'h0F, 8'hFF, 8'hFF);
    $display("test sector erase done");
    op(8'h87, 8'h02, 8'h20, 8'h00, 8'h00, 0);
    rchk(8'hE7, 8'h10, "fail bit");
    fread(8'h0C, 8'h00, 8'hFF);
    rchk(8'hE7, 8'h00, "fail bit");
    app_code_running = 1'b1;
    op(8'h87, 8'h02, 8'h10, 8'h00, 8'h00, 0);
    rchk(8'hE7, 8'h10, "fail bit");
    op(8'h87, 8'h02, 8'h0E, 8'h10, 8'h3C, PU);
    app_code_running = 1'b0;
    fread(8'h0E, 8'h10, 8'h3C);
    op(8'h07, 8'h02, 8'h0E, 8'h11, 8'h00, 0);
    rchk(8'hE7, 8'h00, "fail bit");
    fread(8'h0E, 8'h11, 8'hFF);
    op(8'h87, 8'h00, 8'h0E, 8'h11, 8'h00, 0);
    $display("test refusals done");
    core.wr(8'hE7, 8'h87);
    core.wr(8'hE5, 8'h01);
    core.wr(8'hE6, 8'h46);
    core.wr(8'hE6, 8'h00);
    core.wr(8'hE6, 8'hB9);
    stall_chk(0);
    core.wr(8'hE6, 8'h46);
    core.wr(8'hE6, 8'h46);
    core.wr(8'hE6, 8'hB9);
    stall_chk(2);
    core.wr(8'hE6, 8'hB9);
    stall_chk(0);
    core.wr(8'hE7, 8'h7F);
    rchk(8'hE7, 8'h4F, "control");
    core.idle();
    $display("test trigger sequence done");
    low_voltage_detect = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    low_voltage_detect = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rchk(8'h87, 8'h20, "low-voltage flag");
    core.wr(8'h87, 8'h00);
    rchk(8'h87, 8'h00, "low-voltage flag");
    $display("test low voltage done");
    report_and_stop();
  end
endmodule : tb_data_flash_iap_controller

/* File: src/data_flash_iap_controller.sv */
/*
  Data flash access controller behind the special function registers:
  byte read, byte program and sector erase of a 4 KB data flash, started
  by a two-write trigger, with the core stalled until the operation ends.
  Also holds the power control register with its low-voltage flag.
  Assumes the core stops issuing register accesses while cpu_stall is
  high, and that app_code_running comes from logic on the same clock.
*/
`timescale 1ns/1ps
`include "flash_iap_consts.svh"

module data_flash_iap_controller #(
  parameter int PROGRAM_UNIT_CLKS = `PROGRAM_UNIT_CLKS,
  parameter int ERASE_UNIT_CLKS = `ERASE_UNIT_CLKS
) (
  input wire logic clk, // System clock, 200 MHz.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic [7:0] sfr_addr, // Register address.
  input wire logic sfr_wr, // Register write strobe.
  input wire logic [7:0] sfr_wdata, // Register write data.
  input wire logic sfr_rd, // Register read strobe.
  output logic [7:0] sfr_rdata, // Read data, one cycle after sfr_rd.
  input wire logic low_voltage_detect, // Supply below threshold, async.
  input wire logic app_code_running, // Core runs from application area.
  output logic cpu_stall // Holds the core during an operation.
);

  logic [7:0] power_control;
  logic [7:0] flash_data_port;
  logic [7:0] flash_address_high;
  logic [7:0] flash_address_low;
  flash_iap_pkg::op_t flash_command;
  logic flash_function_enable;
  logic boot_select;
  logic control_reserved;
  logic [2:0] wait_select;
  logic command_fail;
  flash_iap_pkg::state_t state;
  flash_iap_pkg::op_t op_kind;
  logic [`COUNT_W-1:0] count;
  logic [`COUNT_W-1:0] stall_len;
  logic lvd_meta;
  logic lvd_sync;
  logic fire;
  logic trig_wr;
  logic done;
  logic program_strobe;
  logic erase_strobe;
  logic [7:0] rd_byte;
  logic [5:0] wait_mult;
  logic [`COUNT_W-1:0] program_clks;
  logic [`COUNT_W-1:0] erase_clks;
  logic bad_high;
  logic app_target;

  function automatic logic wr_to(input logic [7:0] a);
    return sfr_wr && (sfr_addr == a);
  endfunction : wr_to

  // Written out so that the net follows the bus, not only its arguments.
  assign trig_wr = sfr_wr && (sfr_addr == `ADDR_FLASH_TRIGGER);
  assign done = (state == flash_iap_pkg::ST_BUSY) && (count == '0);
  assign program_strobe = done && (op_kind == flash_iap_pkg::OP_PROGRAM);
  assign erase_strobe = done && (op_kind == flash_iap_pkg::OP_ERASE);
  assign bad_high = |flash_address_high[7:5];
  assign app_target = flash_address_high[4];

  always_comb begin
    case (wait_select)
      3'h0: wait_mult = `WAIT_MULT_0;
      3'h1: wait_mult = `WAIT_MULT_1;
      3'h2: wait_mult = `WAIT_MULT_2;
      3'h3: wait_mult = `WAIT_MULT_3;
      3'h4: wait_mult = `WAIT_MULT_4;
      3'h5: wait_mult = `WAIT_MULT_5;
      3'h6: wait_mult = `WAIT_MULT_6;
      default: wait_mult = `WAIT_MULT_7;
    endcase
  end

  assign program_clks = `COUNT_W'(PROGRAM_UNIT_CLKS * int'(wait_mult));
  assign erase_clks = `COUNT_W'(ERASE_UNIT_CLKS * int'(wait_mult));

  trigger_unlock u_unlock (
    .clk(clk),
    .reset(reset),
    .trig_wr(trig_wr),
    .trig_data(sfr_wdata),
    .function_enable(flash_function_enable),
    .fire(fire)
  );

  // Low twelve address bits select the byte.
  flash_byte_array #(
    .DEPTH(`FLASH_BYTES),
    .SECTOR(`SECTOR_BYTES)
  ) u_array (
    .clk(clk),
    .reset(reset),
    .addr({flash_address_high[3:0], flash_address_low}),
    .wdata(flash_data_port),
    .program_strobe(program_strobe),
    .erase_strobe(erase_strobe),
    .rd_byte(rd_byte)
  );

  // Supply detector is asynchronous to the system clock.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lvd_meta <= 1'b0;
      lvd_sync <= 1'b0;
    end else begin
      lvd_meta <= low_voltage_detect;
      lvd_sync <= lvd_meta;
    end
  end

  // Sticky low-voltage flag, set wins over a clearing write.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_control <= `RESET_POWER_CONTROL;
    end else begin
      if (wr_to(`ADDR_POWER_CONTROL)) begin
        power_control <= sfr_wdata;
      end
      if (lvd_sync) begin
        power_control[`BIT_LOW_VOLTAGE_FLAG] <= 1'b1;
      end
    end
  end

  // Address and command change only by software writes.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flash_address_high <= `RESET_FLASH_ADDRESS;
      flash_address_low <= `RESET_FLASH_ADDRESS;
      flash_command <= flash_iap_pkg::op_t'(`RESET_FLASH_COMMAND);
    end else begin
      if (wr_to(`ADDR_FLASH_ADDRESS_HIGH)) begin
        flash_address_high <= sfr_wdata;
      end
      if (wr_to(`ADDR_FLASH_ADDRESS_LOW)) begin
        flash_address_low <= sfr_wdata;
      end
      if (wr_to(`ADDR_FLASH_COMMAND)) begin
        flash_command <= flash_iap_pkg::op_t'(sfr_wdata[1:0]);
      end
    end
  end

  // Read result lands in the data register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flash_data_port <= `RESET_FLASH_DATA_PORT;
    end else if (done && (op_kind == flash_iap_pkg::OP_READ)) begin
      flash_data_port <= rd_byte;
    end else if (wr_to(`ADDR_FLASH_DATA_PORT)) begin
      flash_data_port <= sfr_wdata;
    end
  end

  // Software-owned control fields; the fail bit belongs to hardware.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flash_function_enable <= 1'b0;
      boot_select <= 1'b0;
      control_reserved <= `RESET_CONTROL_RESERVED;
      wait_select <= `RESET_WAIT_SELECT;
    end else if (wr_to(`ADDR_FLASH_CONTROL)) begin
      flash_function_enable <= sfr_wdata[`BIT_FUNCTION_ENABLE];
      boot_select <= sfr_wdata[`BIT_BOOT_SELECT];
      control_reserved <= sfr_wdata[`BIT_CONTROL_RESERVED];
      wait_select <= sfr_wdata[2:0];
    end
  end

  // Operation sequencer.
  // Stall lasts exactly the selected count of cycles.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= flash_iap_pkg::ST_IDLE;
      op_kind <= flash_iap_pkg::OP_STANDBY;
      count <= '0;
      cpu_stall <= 1'b0;
      command_fail <= 1'b0;
    end else begin
      case (state)
        flash_iap_pkg::ST_IDLE: begin
          if (fire) begin
            op_kind <= flash_command;
            case (flash_command)
              flash_iap_pkg::OP_READ: begin
                state <= flash_iap_pkg::ST_BUSY;
                cpu_stall <= 1'b1;
                count <= `READ_CLKS - `COUNT_W'(1);
              end
              flash_iap_pkg::OP_PROGRAM, flash_iap_pkg::OP_ERASE: begin
                if (bad_high || (app_code_running && app_target)) begin
                  command_fail <= 1'b1;
                end else begin
                  state <= flash_iap_pkg::ST_BUSY;
                  cpu_stall <= 1'b1;
                  count <= ((flash_command == flash_iap_pkg::OP_PROGRAM) ?
                            program_clks : erase_clks) - `COUNT_W'(1);
                end
              end
              default: begin
              end
            endcase
          end
        end
        flash_iap_pkg::ST_BUSY: begin
          if (count == '0) begin
            state <= flash_iap_pkg::ST_IDLE;
            cpu_stall <= 1'b0;
            command_fail <= 1'b0;
          end else begin
            count <= count - `COUNT_W'(1);
          end
        end
        default: begin
          state <= flash_iap_pkg::ST_IDLE;
          cpu_stall <= 1'b0;
        end
      endcase
    end
  end

  // Registered read port; unmapped addresses read as zero.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sfr_rdata <= `UNMAPPED_READ;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `ADDR_POWER_CONTROL: sfr_rdata <= power_control;
        `ADDR_FLASH_DATA_PORT: sfr_rdata <= flash_data_port;
        `ADDR_FLASH_ADDRESS_HIGH: sfr_rdata <= flash_address_high;
        `ADDR_FLASH_ADDRESS_LOW: sfr_rdata <= flash_address_low;
        `ADDR_FLASH_COMMAND: sfr_rdata <= {6'h00, flash_command};
        `ADDR_FLASH_CONTROL: begin
          sfr_rdata <= {flash_function_enable, boot_select, 1'b0,
                        command_fail, control_reserved, wait_select};
        end
        default: sfr_rdata <= `UNMAPPED_READ;
      endcase
    end
  end

  // Counts stall cycles so the length can be checked at its end.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stall_len <= '0;
    end else begin
      stall_len <= cpu_stall ? stall_len + `COUNT_W'(1) : '0;
    end
  end

  a_low_voltage_set : assert property (@(posedge clk)
    disable iff (reset) lvd_sync |=> power_control[`BIT_LOW_VOLTAGE_FLAG])
    else $error("Low-voltage flag not set.");

  a_app_write_ignored : assert property (@(posedge clk)
    disable iff (reset)
    fire && (state == flash_iap_pkg::ST_IDLE) && app_code_running &&
      app_target && flash_command[1] |=> !cpu_stall && command_fail)
    else $error("Application area write was not ignored.");

  a_high_bits_fail : assert property (@(posedge clk)
    disable iff (reset) fire && (state == flash_iap_pkg::ST_IDLE) &&
      bad_high && flash_command[1] |=> command_fail && !cpu_stall)
    else $error("Out-of-range write did not fail.");

  a_read_two_clocks : assert property (@(posedge clk)
    disable iff (reset) fire && (state == flash_iap_pkg::ST_IDLE) &&
      (flash_command == flash_iap_pkg::OP_READ) |=>
      cpu_stall [*2] ##1 !cpu_stall)
    else $error("Read stall is not two clocks.");

  a_program_length : assert property (@(posedge clk)
    disable iff (reset) $fell(cpu_stall) &&
      (op_kind == flash_iap_pkg::OP_PROGRAM) |-> stall_len == program_clks)
    else $error("Program stall length wrong.");

  a_stall_after_fire : assert property (@(posedge clk)
    disable iff (reset) fire && (state == flash_iap_pkg::ST_IDLE) &&
      (flash_command != flash_iap_pkg::OP_STANDBY) && !bad_high &&
      !(app_code_running && app_target) |=> cpu_stall)
    else $error("Core not stalled after a valid trigger.");

  a_address_held : assert property (@(posedge clk)
    disable iff (reset) $fell(cpu_stall) |=> $stable(flash_address_high) &&
      $stable(flash_address_low) || $past(sfr_wr))
    else $error("Address changed after an operation.");

  a_read_data : assert property (@(posedge clk)
    disable iff (reset) $fell(cpu_stall) &&
      (op_kind == flash_iap_pkg::OP_READ) |->
      flash_data_port == $past(rd_byte))
    else $error("Read byte not placed in the data register.");

  a_fail_cleared : assert property (@(posedge clk)
    disable iff (reset) $fell(cpu_stall) |-> !command_fail)
    else $error("Fail bit not cleared on success.");

endmodule : data_flash_iap_controller

/* File: src/flash_byte_array.sv */
/*
  Byte array standing in for the data flash: byte program can only clear
  bits, sector erase returns a whole sector to the erased value.
  Assumes strobes are single cycles with a stable address.
*/
`timescale 1ns/1ps
`include "flash_iap_consts.svh"

module flash_byte_array #(
  parameter int DEPTH = `FLASH_BYTES,
  parameter int SECTOR = `SECTOR_BYTES
) (
  input wire logic clk, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic [$clog2(DEPTH)-1:0] addr, // Byte address.
  input wire logic [7:0] wdata, // Program data.
  input wire logic program_strobe, // Program the addressed byte.
  input wire logic erase_strobe, // Erase the sector holding addr.
  output logic [7:0] rd_byte // Content of the addressed byte.
);

  localparam int AW = $clog2(DEPTH);
  localparam int SW = $clog2(SECTOR);

  logic [7:0] mem [DEPTH];
  logic [7:0] programmed;

  assign rd_byte = mem[addr];
  assign programmed = mem[addr] & wdata;

  // Per-byte storage.
  // Erase hits every byte of the sector; program ANDs one byte.
  for (genvar g = 0; g < DEPTH; g++) begin : g_byte
    localparam logic [AW-1:0] IDX = AW'(g);
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        mem[g] <= `ERASED_BYTE;
      end else if (erase_strobe && (addr[AW-1:SW] == IDX[AW-1:SW])) begin
        mem[g] <= `ERASED_BYTE;
      end else if (program_strobe && (addr == IDX)) begin
        mem[g] <= mem[g] & wdata;
      end
    end
  end

  a_program_clears : assert property (@(posedge clk)
    disable iff (reset) program_strobe |=>
      mem[$past(addr)] == $past(programmed))
    else $error("Program did not AND the byte with the data.");

  a_erase_sector : assert property (@(posedge clk)
    disable iff (reset) erase_strobe |=>
      mem[{$past(addr[AW-1:SW]), {SW{1'b0}}}] == `ERASED_BYTE &&
      mem[{$past(addr[AW-1:SW]), {SW{1'b1}}}] == `ERASED_BYTE)
    else $error("Sector bounds not erased.");

endmodule : flash_byte_array

/* File: src/flash_iap_consts.svh */
/*
  Constants of the data flash access controller: special function register
  addresses, reset values, field positions, trigger keys and stall counts.
  Assumes it is included by its bare name, once per compilation unit.
*/
`ifndef FLASH_IAP_CONSTS_SVH
`define FLASH_IAP_CONSTS_SVH

`define ADDR_POWER_CONTROL 8'h87
`define ADDR_FLASH_DATA_PORT 8'hE2
`define ADDR_FLASH_ADDRESS_HIGH 8'hE3
`define ADDR_FLASH_ADDRESS_LOW 8'hE4
`define ADDR_FLASH_COMMAND 8'hE5
`define ADDR_FLASH_TRIGGER 8'hE6
`define ADDR_FLASH_CONTROL 8'hE7

`define RESET_POWER_CONTROL 8'h00
`define RESET_FLASH_DATA_PORT 8'hFF
`define RESET_FLASH_ADDRESS 8'h00
`define RESET_FLASH_COMMAND 2'h0
`define RESET_WAIT_SELECT 3'h0
`define RESET_CONTROL_RESERVED 1'h1
`define UNMAPPED_READ 8'h00

`define BIT_LOW_VOLTAGE_FLAG 5
`define BIT_FUNCTION_ENABLE 7
`define BIT_BOOT_SELECT 6
`define BIT_CONTROL_RESERVED 3

`define TRIGGER_KEY_FIRST 8'h46
`define TRIGGER_KEY_SECOND 8'hB9

`define CODE_STANDBY 2'h0
`define CODE_BYTE_READ 2'h1
`define CODE_BYTE_PROGRAM 2'h2
`define CODE_SECTOR_ERASE 2'h3

`define FLASH_BYTES 4096
`define SECTOR_BYTES 512
`define ERASED_BYTE 8'hFF

`define COUNT_W 20
`define READ_CLKS 20'h00002
`define PROGRAM_UNIT_CLKS 55
`define ERASE_UNIT_CLKS 21012
`define WAIT_MULT_0 6'h20
`define WAIT_MULT_1 6'h18
`define WAIT_MULT_2 6'h14
`define WAIT_MULT_3 6'h0C
`define WAIT_MULT_4 6'h06
`define WAIT_MULT_5 6'h03
`define WAIT_MULT_6 6'h02
`define WAIT_MULT_7 6'h01

`endif

/* File: src/flash_iap_pkg.sv */
/*
  Types of the data flash access controller: controller states and the
  operation codes of the command register.
  Assumes flash_iap_consts.svh is on the include path.
*/
`include "flash_iap_consts.svh"

package flash_iap_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } state_t;

  typedef enum logic [1:0] {
    OP_STANDBY = `CODE_STANDBY,
    OP_READ = `CODE_BYTE_READ,
    OP_PROGRAM = `CODE_BYTE_PROGRAM,
    OP_ERASE = `CODE_SECTOR_ERASE
  } op_t;

endpackage : flash_iap_pkg

/* File: src/trigger_unlock.sv */
/*
  Two-write unlock of the trigger register: a first key followed directly
  by the second key yields a one-cycle start pulse.
  Assumes trigger writes come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "flash_iap_consts.svh"

module trigger_unlock (
  input wire logic clk, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic trig_wr, // Write strobe to the trigger register.
  input wire logic [7:0] trig_data, // Data written to the trigger register.
  input wire logic function_enable, // Enable bit of the control register.
  output logic fire // One-cycle start pulse.
);

  logic armed;

  // Arming on first key.
  // Any trigger write other than the first key drops the sequence; a repeated first key keeps it armed.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (trig_wr) begin
      armed <= (trig_data == `TRIGGER_KEY_FIRST);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fire <= 1'b0;
    end else begin
      fire <= trig_wr && armed && function_enable &&
              (trig_data == `TRIGGER_KEY_SECOND);
    end
  end

  a_fire_after_pair : assert property (@(posedge clk)
    disable iff (reset) fire |-> $past(trig_wr) && $past(armed) &&
      ($past(trig_data) == `TRIGGER_KEY_SECOND))
    else $error("Start pulse without a complete key pair.");

  a_wrong_key_drops : assert property (@(posedge clk)
    disable iff (reset) armed && trig_wr &&
      (trig_data != `TRIGGER_KEY_FIRST) |=> !armed ##1 !fire)
    else $error("Sequence not dropped after a wrong key.");

  a_enable_gates : assert property (@(posedge clk)
    disable iff (reset) fire |-> $past(function_enable))
    else $error("Start pulse while the function was disabled.");

endmodule : trigger_unlock
